// ---- verilog/vip_map.svh ----
/*
 offsets, reset values, vectors and source positions of the interrupt
 priority logic. assumes a single inclusion guard and bare-name include.
*/
`ifndef VIP_MAP_SVH
`define VIP_MAP_SVH

`define VIP_NUM_SRC        23
`define VIP_NUM_EXT        8
`define VIP_NUM_INT        15

`define VIP_OFS_REQ        8'h00
`define VIP_OFS_MASK       8'h04
`define VIP_OFS_PRIO       8'h08
`define VIP_OFS_CTRL       8'h0c
`define VIP_OFS_STAT       8'h10

`define VIP_RST_REQ        23'h000000
`define VIP_RST_MASK       23'h7fffff
`define VIP_RST_PRIO       23'h7fffff

`define VIP_CTRL_EN_BIT    0
`define VIP_CTRL_LVM_BIT   1

`define VIP_VEC_RESET      16'h0000
`define VIP_VEC_BASE       16'h0004
`define VIP_VEC_TRAP       16'h003e

`define VIP_SRC_LVI        5'd0
`define VIP_SRC_PIN0       5'd1
`define VIP_SRC_SERB_ERR   5'd7
`define VIP_SRC_SHARED     5'd10
`define VIP_SRC_TMH_B      5'd11
`define VIP_SRC_CONV       5'd16
`define VIP_SRC_SERA_RX    5'd17
`define VIP_SRC_WATCH_INT  5'd18
`define VIP_SRC_T8_B       5'd19
`define VIP_SRC_KEY        5'd20
`define VIP_SRC_WATCH_OVF  5'd21
`define VIP_SRC_PIN6       5'd22

`endif

// ---- verilog/vip_pkg.sv ----
/*
 types of the interrupt priority logic.
 assumes vip_map.svh is on the include path.
*/
`default_nettype none
`include "vip_map.svh"

package vip_pkg;

   typedef logic [`VIP_NUM_SRC-1:0] vip_src_t;

   typedef enum logic [1:0] {
      VIP_IDLE  = 2'b01,
      VIP_OFFER = 2'b10
   } vip_state_t;

   typedef struct packed {
      vip_src_t   flag;
      vip_src_t   mask;
      vip_src_t   prio;
      logic       gen_en;
      logic       lv_mode;
      logic       isp_hi;
      logic       isp_lo;
      logic       trap_pend;
      vip_state_t fsm;
      logic       trap_q;
      logic [4:0] ent_q;
      logic [15:0] vec_q;
      logic       standby;
      logic       rst_req;
   } vip_core_t;

endpackage

`default_nettype wire

// ---- verilog/vip_reg_if.sv ----
/*
 register strobe bundle between the bus front end and the core.
 assumes one clock; the core answers reads in the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none

interface vip_reg_if;
   logic        wr;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        hit;

   modport bus  (output wr, output addr, output wdata,
                 input rdata, input hit);
   modport core (input wr, input addr, input wdata,
                 output rdata, output hit);
endinterface

`default_nettype wire

// ---- verilog/vip_pick.sv ----
/*
 fixed order picker: lowest set index wins.
 assumes a purely combinational use.
*/
`timescale 1ns/10ps
`default_nettype none

module vip_pick #(
   parameter int N = 23
) (
   input  wire logic [N-1:0] elig,
   output logic              valid,
   output logic [4:0]        idx
);
   always_comb begin
      valid = 1'b0;
      idx   = 5'h00;
      for (int i = N - 1; i >= 0; i--) begin
         if (elig[i]) begin
            valid = 1'b1;
            idx   = 5'(i);
         end
      end
   end
endmodule

`default_nettype wire

// ---- verilog/vip_apb.sv ----
/*
 apb slave front end: zero wait states, error on unmapped address.
 assumes the core decodes addresses and answers through vip_reg_if.
*/
`timescale 1ns/10ps
`default_nettype none

module vip_apb (
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   vip_reg_if.bus           rb
);
   logic access;

   assign access   = psel & penable;
   assign pready   = 1'b1;
   assign rb.addr  = paddr;
   assign rb.wdata = pwdata;
   // writes land only on mapped words
   assign rb.wr    = access & pwrite & rb.hit;
   assign prdata   = (access & ~pwrite & rb.hit) ? rb.rdata : 32'h00000000;
   assign pslverr  = access & ~rb.hit;
endmodule

`default_nettype wire

// ---- verilog/vip_top.sv ----
/*
 vectored interrupt priority logic: flags, masks, priority groups,
 nesting, software trap and reset vector.
 assumes one-cycle request pulses from peripherals and a core that
 pulses int_ack to take an offer and int_done on return.
*/
// Register access over APB and the address map were chosen for this implementation.
// Contract
// - software sets a priority group flag per maskable source
// - a high group request may nest into low group service
// - same group ties resolve by fixed order, 0 highest
// - any unmasked pending request raises standby release
// - eight external and fifteen internal maskable request inputs
// - software trap always taken, outside priority arbitration
// - software trap vectors to 003eh
// - pin sources at priorities 1-6 and 22 with their vectors
// - serial port b error, rx, tx at priorities 7, 8, 9
// - clocked serial and serial a tx share entry 10
// - timers at priorities 11-15 and 19 with their vectors
// - conversion at 16, serial a receive at 17
// - watch interval 18, key input 20, watch overflow 21
// - low voltage is maskable only when mode select is 0
// - all reset causes restart from vector 0000h
// - acknowledgement clears that source's request flag
// - shared flag sets on either of its two sources
// - reset clears all request flags
`timescale 1ns/10ps
`default_nettype none
`include "vip_map.svh"

module vip_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  ext_request,
   input  wire logic [14:0] int_request,
   input  wire logic        serial_a_tx_done_request,
   input  wire logic        software_trap_instruction,
   input  wire logic        int_ack,
   input  wire logic        int_done,
   output logic             int_req,
   output logic [15:0]      int_vector,
   output logic             standby_release,
   input  wire logic        reset_pin,
   input  wire logic        power_on_clear,
   input  wire logic        low_voltage_request,
   input  wire logic        osc_stop_detect,
   input  wire logic        watchdog_overflow,
   output logic             reset_request,
   output logic [15:0]      reset_vector
);
   vip_reg_if          rb ();
   vip_pkg::vip_core_t s_q;
   vip_pkg::vip_core_t s_d;
   vip_pkg::vip_src_t  set_v;
   vip_pkg::vip_src_t  elig;
   vip_pkg::vip_src_t  ack_clr;
   logic               hi_valid;
   logic               lo_valid;
   logic [4:0]         hi_idx;
   logic [4:0]         lo_idx;
   logic               take_hi;
   logic               take_lo;
   logic [31:0]        stat;

   vip_apb u_apb (
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .rb      (rb)
   );

   // request inputs onto fixed order entries
   always_comb begin
      set_v = '0;
      set_v[`VIP_SRC_LVI] = int_request[0] & ~s_q.lv_mode;
      for (int i = 0; i < 6; i++) begin
         set_v[`VIP_SRC_PIN0 + i] = ext_request[i];
      end
      for (int i = 0; i < 3; i++) begin
         set_v[`VIP_SRC_SERB_ERR + i] = int_request[1 + i];
      end
      set_v[`VIP_SRC_SHARED] = int_request[4] |
                               serial_a_tx_done_request;
      for (int i = 0; i < 5; i++) begin
         set_v[`VIP_SRC_TMH_B + i] = int_request[5 + i];
      end
      set_v[`VIP_SRC_CONV]      = int_request[10];
      set_v[`VIP_SRC_SERA_RX]   = int_request[11];
      set_v[`VIP_SRC_WATCH_INT] = int_request[12];
      set_v[`VIP_SRC_T8_B]      = int_request[13];
      set_v[`VIP_SRC_KEY]       = ext_request[7];
      set_v[`VIP_SRC_WATCH_OVF] = int_request[14];
      set_v[`VIP_SRC_PIN6]      = ext_request[6];
   end

   // eligible: flagged and unmasked, split by group
   assign elig = s_q.flag & ~s_q.mask;

   vip_pick #(.N(`VIP_NUM_SRC)) u_pick_hi (
      .elig  (elig & ~s_q.prio),
      .valid (hi_valid),
      .idx   (hi_idx)
   );

   vip_pick #(.N(`VIP_NUM_SRC)) u_pick_lo (
      .elig  (elig & s_q.prio),
      .valid (lo_valid),
      .idx   (lo_idx)
   );

   // high group wins; it may nest into low service only
   assign take_hi = s_q.gen_en & hi_valid & ~s_q.isp_hi;
   assign take_lo = s_q.gen_en & lo_valid & ~s_q.isp_hi & ~s_q.isp_lo
                    & ~take_hi;

   // register read and decode
   assign stat = {7'h00, s_q.ent_q, s_q.vec_q[15:0], s_q.trap_q,
                  s_q.isp_lo, s_q.isp_hi, s_q.fsm == vip_pkg::VIP_OFFER};
   always_comb begin
      rb.hit   = 1'b1;
      rb.rdata = 32'h00000000;
      unique case (rb.addr)
         `VIP_OFS_REQ:  rb.rdata = {9'h000, s_q.flag};
         `VIP_OFS_MASK: rb.rdata = {9'h000, s_q.mask};
         `VIP_OFS_PRIO: rb.rdata = {9'h000, s_q.prio};
         `VIP_OFS_CTRL: rb.rdata = {30'h00000000, s_q.lv_mode, s_q.gen_en};
         `VIP_OFS_STAT: rb.rdata = stat;
         default:       rb.hit   = 1'b0;
      endcase
   end

   always_comb begin
      s_d     = s_q;
      ack_clr = '0;
      if (rb.wr) begin
         unique case (rb.addr)
            `VIP_OFS_REQ:  s_d.flag = rb.wdata[`VIP_NUM_SRC-1:0];
            `VIP_OFS_MASK: s_d.mask = rb.wdata[`VIP_NUM_SRC-1:0];
            `VIP_OFS_PRIO: s_d.prio = rb.wdata[`VIP_NUM_SRC-1:0];
            `VIP_OFS_CTRL: begin
               s_d.gen_en  = rb.wdata[`VIP_CTRL_EN_BIT];
               s_d.lv_mode = rb.wdata[`VIP_CTRL_LVM_BIT];
            end
            default: ;
         endcase
      end
      if (software_trap_instruction) begin
         s_d.trap_pend = 1'b1;
      end
      if (int_done) begin
         if (s_q.isp_hi) begin
            s_d.isp_hi = 1'b0;
         end else begin
            s_d.isp_lo = 1'b0;
         end
      end
      unique case (s_q.fsm)
         vip_pkg::VIP_IDLE: begin
            if (s_q.trap_pend) begin
               s_d.fsm    = vip_pkg::VIP_OFFER;
               s_d.trap_q = 1'b1;
               s_d.vec_q  = `VIP_VEC_TRAP;
            end else if (take_hi | take_lo) begin
               s_d.fsm    = vip_pkg::VIP_OFFER;
               s_d.trap_q = 1'b0;
               s_d.ent_q  = take_hi ? hi_idx : lo_idx;
               s_d.vec_q  = `VIP_VEC_BASE +
                            {10'h000, (take_hi ? hi_idx : lo_idx), 1'b0};
            end
         end
         vip_pkg::VIP_OFFER: begin
            if (int_ack) begin
               s_d.fsm = vip_pkg::VIP_IDLE;
               if (s_q.trap_q) begin
                  s_d.trap_pend = software_trap_instruction;
               end else begin
                  ack_clr[s_q.ent_q] = 1'b1;
                  if (s_q.prio[s_q.ent_q]) begin
                     s_d.isp_lo = 1'b1;
                  end else begin
                     s_d.isp_hi = 1'b1;
                  end
               end
            end
         end
      endcase
      // hardware set wins over ack and software clear
      s_d.flag    = (s_d.flag & ~ack_clr) | set_v;
      s_d.standby = |(s_d.flag & ~s_d.mask);
      s_d.rst_req = reset_pin | power_on_clear | osc_stop_detect |
                    watchdog_overflow |
                    (low_voltage_request & s_q.lv_mode);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.flag      <= `VIP_RST_REQ;
         s_q.mask      <= `VIP_RST_MASK;
         s_q.prio      <= `VIP_RST_PRIO;
         s_q.gen_en    <= 1'b0;
         s_q.lv_mode   <= 1'b0;
         s_q.isp_hi    <= 1'b0;
         s_q.isp_lo    <= 1'b0;
         s_q.trap_pend <= 1'b0;
         s_q.fsm       <= vip_pkg::VIP_IDLE;
         s_q.trap_q    <= 1'b0;
         s_q.ent_q     <= 5'h00;
         s_q.vec_q     <= `VIP_VEC_RESET;
         s_q.standby   <= 1'b0;
         s_q.rst_req   <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign int_req         = s_q.fsm == vip_pkg::VIP_OFFER;
   assign int_vector      = s_q.vec_q;
   assign standby_release = s_q.standby;
   assign reset_request   = s_q.rst_req;
   assign reset_vector    = `VIP_VEC_RESET;

   // checks
   sequence s_offer_mask;
      int_req && !s_q.trap_q;
   endsequence

   sequence s_taken;
      s_offer_mask ##0 int_ack;
   endsequence

   chk_trap_vector: assert property (
      @(posedge pclk) disable iff (!presetn)
      int_req && s_q.trap_q |-> int_vector == 16'h003e)
      else $error("trap offered with wrong vector");

   chk_trap_taken: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_q.trap_pend && !int_req |=> int_req && s_q.trap_q)
      else $error("pending trap not offered");

   chk_ack_clears: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_taken ##0 !set_v[s_q.ent_q]
      |=> !s_q.flag[$past(s_q.ent_q)] && !int_req)
      else $error("acknowledged flag not cleared");

   chk_vector_map: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_offer_mask |-> int_vector == 16'h0004 + 16'(s_q.ent_q) * 2)
      else $error("vector does not match entry");

   chk_standby_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      |(s_q.flag & ~s_q.mask) && $stable(s_q.flag) && !rb.wr
      |-> standby_release)
      else $error("standby release missing");

   chk_no_nest_hi: assert property (
      @(posedge pclk) disable iff (!presetn)
      !int_req && s_q.isp_hi && !s_q.trap_pend
      |=> !int_req)
      else $error("offer while high group in service");

   chk_nest_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      !int_req && s_q.isp_lo && !s_q.isp_hi && s_q.gen_en && hi_valid
      && !s_q.trap_pend |=> int_req && s_q.ent_q == $past(hi_idx))
      else $error("high request did not nest");

   chk_fixed_order: assert property (
      @(posedge pclk) disable iff (!presetn)
      !int_req && !s_q.trap_pend && take_lo
      |=> int_req && s_q.ent_q == $past(lo_idx))
      else $error("fixed order not kept");

   chk_shared_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      serial_a_tx_done_request |=> s_q.flag[10])
      else $error("shared flag not set");

   chk_reset_cause: assert property (
      @(posedge pclk) disable iff (!presetn)
      watchdog_overflow || reset_pin || (low_voltage_request && s_q.lv_mode)
      |=> reset_request && reset_vector == 16'h0000)
      else $error("reset cause not reported");

   chk_lvi_maskable: assert property (
      @(posedge pclk) disable iff (!presetn)
      int_request[0] && s_q.lv_mode && !rb.wr && !s_q.flag[0]
      |=> !s_q.flag[0])
      else $error("low voltage flagged in reset mode");

   chk_offer_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      int_req && !int_ack |=> int_req && $stable(int_vector))
      else $error("offer withdrawn before acknowledge");

   chk_off_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      !int_req && !s_q.gen_en && !s_q.trap_pend |=> !int_req)
      else $error("offer while globally disabled");

   chk_masked_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      !int_req && !s_q.trap_pend && !(|elig) |=> !int_req)
      else $error("offer with nothing eligible");

   chk_group_first: assert property (
      @(posedge pclk) disable iff (!presetn)
      !int_req && !s_q.trap_pend && take_hi && lo_valid
      |=> int_req && s_q.ent_q == $past(hi_idx))
      else $error("low group beat high group");

   chk_isp_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_taken ##0 !s_q.prio[s_q.ent_q] |=> s_q.isp_hi)
      else $error("high group service not recorded");

   chk_trap_no_isp: assert property (
      @(posedge pclk) disable iff (!presetn)
      int_req && s_q.trap_q && int_ack && !int_done
      |=> $stable(s_q.isp_hi) && $stable(s_q.isp_lo))
      else $error("trap changed service levels");

   chk_reset_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      !reset_pin && !power_on_clear && !osc_stop_detect
      && !watchdog_overflow && !low_voltage_request |=> !reset_request)
      else $error("reset request without cause");
endmodule

`default_nettype wire

// ---- verification/vip_core_model.sv ----
/*
 core side partner: takes offered interrupts and signals return.
 assumes int_req stands until int_ack is seen at a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module vip_core_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       int_req,
   input  wire logic [3:0] lag,
   input  wire logic       ret,
   output logic            int_ack,
   output logic            int_done
);
   logic [3:0] wait_q;

   // ack after lag + 1 cycles of a standing offer, one cycle wide
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_ack  <= 1'b0;
         int_done <= 1'b0;
         wait_q   <= 4'h0;
      end else begin
         int_done <= ret;
         if (int_ack || !int_req) begin
            int_ack <= 1'b0;
            wait_q  <= 4'h0;
         end else if (wait_q == lag) begin
            int_ack <= 1'b1;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule

`default_nettype wire

// ---- verification/vip_top_test.sv ----
/*
 self-checking bench of vip_top with a core model on its far side.
 assumes vip_map.svh on the include path and the core model compiled.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vip_map.svh"

module vip_top_test;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [24:0] req_v;
   logic [4:0]  rc;
   logic        int_ack;
   logic        int_done;
   logic        int_req;
   logic [15:0] int_vector;
   logic        standby_release;
   logic        reset_request;
   logic [15:0] reset_vector;
   logic [3:0]  lag;
   logic        ret;
   int          errors;
   int          total_checks;
   int          ent [24] = '{1, 2, 3, 4, 5, 6, 22, 20, 0, 7, 8, 9, 10, 11,
                             12, 13, 14, 15, 16, 17, 18, 19, 21, 10};

   always #4 pclk = ~pclk;

   vip_top dut (
      .pclk                      (pclk),
      .presetn                   (presetn),
      .psel                      (psel),
      .penable                   (penable),
      .pwrite                    (pwrite),
      .paddr                     (paddr),
      .pwdata                    (pwdata),
      .prdata                    (prdata),
      .pready                    (pready),
      .pslverr                   (pslverr),
      .ext_request               (req_v[7:0]),
      .int_request               (req_v[22:8]),
      .serial_a_tx_done_request  (req_v[23]),
      .software_trap_instruction (req_v[24]),
      .int_ack                   (int_ack),
      .int_done                  (int_done),
      .int_req                   (int_req),
      .int_vector                (int_vector),
      .standby_release           (standby_release),
      .reset_pin                 (rc[0]),
      .power_on_clear            (rc[1]),
      .low_voltage_request       (rc[2]),
      .osc_stop_detect           (rc[3]),
      .watchdog_overflow         (rc[4]),
      .reset_request             (reset_request),
      .reset_vector              (reset_vector)
   );

   vip_core_model core (
      .pclk     (pclk),
      .presetn  (presetn),
      .int_req  (int_req),
      .lag      (lag),
      .ret      (ret),
      .int_ack  (int_ack),
      .int_done (int_done)
   );

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic ee);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk("prdata", exp, r);
      chk("pslverr", 32'(ee), 32'(e));
      chk("pready", 32'h1, 32'(pready));
   endtask

   task automatic pulse(input logic [24:0] m);
      @(posedge pclk);
      req_v <= m;
      @(posedge pclk);
      req_v <= 25'h0;
   endtask

   task automatic take(input logic [15:0] exp);
      int n;
      n = 0;
      @(negedge pclk);
      while (!(int_req === 1'b1 && int_ack === 1'b1) && n < 60) begin
         @(negedge pclk);
         n++;
      end
      chk("offer", 32'h1, 32'(int_req & int_ack));
      chk("int_vector", 32'(exp), 32'(int_vector));
   endtask

   task automatic done();
      @(posedge pclk);
      ret <= 1'b1;
      @(posedge pclk);
      ret <= 1'b0;
   endtask

   task automatic quiet(input int c);
      repeat (c) begin
         @(negedge pclk);
         chk("int_req", 32'h0, 32'(int_req));
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (10000) @(posedge pclk);
      errors++;
      final_report();
   end

   initial begin
      pclk = 0;
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 8'h00;
      pwdata = 32'h0;
      req_v = 25'h0;
      rc = 5'h0;
      lag = 4'h0;
      ret = 0;
      errors = 0;
      total_checks = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`VIP_OFS_REQ, 32'h0, 1'b0);
      rd(`VIP_OFS_MASK, 32'h7fffff, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      chk("reset_vector", 32'h0, 32'(reset_vector));
      wr(`VIP_OFS_CTRL, 32'h1);
      wr(`VIP_OFS_MASK, 32'h0);
      for (int i = 0; i < 24; i++) begin
         pulse(25'(1) << i);
         take(16'(4 + 2 * ent[i]));
         rd(`VIP_OFS_REQ, 32'h0, 1'b0);
         done();
      end
      lag <= 4'h3;
      wr(`VIP_OFS_CTRL, 32'h0);
      pulse(25'h200);
      quiet(4);
      chk("standby", 32'h1, 32'(standby_release));
      wr(`VIP_OFS_MASK, 32'h7fffff);
      repeat (2) @(negedge pclk);
      chk("standby", 32'h0, 32'(standby_release));
      wr(`VIP_OFS_REQ, 32'h0);
      wr(`VIP_OFS_MASK, 32'h0);
      pulse(25'h80010);
      wr(`VIP_OFS_CTRL, 32'h1);
      take(16'h000e);
      done();
      take(16'h0026);
      done();
      wr(`VIP_OFS_PRIO, 32'h6fffff);
      rd(`VIP_OFS_PRIO, 32'h6fffff, 1'b0);
      wr(`VIP_OFS_CTRL, 32'h0);
      pulse(25'h84);
      wr(`VIP_OFS_CTRL, 32'h1);
      take(16'h002c);
      done();
      take(16'h000a);
      pulse(25'h1);
      quiet(8);
      pulse(25'h80);
      take(16'h002c);
      done();
      done();
      take(16'h0006);
      done();
      wr(`VIP_OFS_CTRL, 32'h0);
      pulse(25'h1000000);
      take(16'h003e);
      wr(`VIP_OFS_CTRL, 32'h3);
      pulse(25'h100);
      rd(`VIP_OFS_REQ, 32'h0, 1'b0);
      for (int k = 0; k < 5; k++) begin
         @(posedge pclk);
         rc <= 5'(1) << k;
         @(posedge pclk);
         rc <= 5'h0;
         @(negedge pclk);
         chk("reset_request", 32'h1, 32'(reset_request));
         chk("reset_vector", 32'h0, 32'(reset_vector));
      end
      final_report();
   end
endmodule

`default_nettype wire
